// [bench/srh_ctl_model.sv]
// Remote controller model draining the output queue
`timescale 1ns/1ns
`default_nettype none

module srh_ctl_model (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       en,
    input  wire logic       slow,
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    output logic            out_ready,
    output logic      [7:0] got,
    output logic      [7:0] last
);
    logic tick_r;
    // Reads single bytes whenever told; slow mode stalls alternate cycles
    assign out_ready = en & (~slow | tick_r);
    // Stall toggle, byte count and last byte taken
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tick_r <= 1'b0;
            got    <= 8'h00;
            last   <= 8'h00;
        end else begin
            tick_r <= ~tick_r;
            if (out_valid && out_ready) begin
                got  <= got + 8'h01;
                last <= out_data;
            end
        end
    end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the status reporting core
`timescale 1ns/1ns
`default_nettype none

module testbench;
    logic        clk_sys, srst, psc_clear, serial_link, query_arb;
    logic        op_sum, qu_sum, ms_sum, resp_valid, resp_ready;
    logic        out_valid, out_ready, rd_valid, srq_o, srq_oe_n;
    logic        sfx_ok, sfx_hz_ohm, en, slow;
    logic [17:0] p;
    logic [7:0]  resp_data, out_data, wr_data, rd_data, spoll_data;
    logic [7:0]  sfx_char0, sfx_char1, sfx_exp, got, last;
    logic [7:0]  ev_exp [5] = '{8'h20, 8'h10, 8'h08, 8'h01, 8'h04};
    logic [31:0] sfx_tab [11] = '{32'h5400000C, 32'h47000009,
        32'h4D410006, 32'h4B000003, 32'h4D0000FD, 32'h550000FA,
        32'h4E0000F7, 32'h500000F4, 32'h4D000106, 32'h6B000003,
        32'h58000000};
    int          error_cnt, comparisons;

    srh_core dut (.clk_sys(clk_sys), .srst(srst), .psc_clear(psc_clear),
        .serial_link(serial_link), .operation_summary(op_sum),
        .questionable_summary(qu_sum), .measurement_summary(ms_sum),
        .ev_cmd_err(p[0]), .ev_exe_err(p[1]), .instrument_error_flag(p[2]),
        .ev_op_done(p[3]), .read_no_query(p[4]), .clear_status(p[5]),
        .instr_clear(p[6]), .msg_start(p[7]), .msg_end(p[8]),
        .query_start(p[9]), .query_arb(query_arb), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_ready(resp_ready),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .sre_wr(p[15]), .ese_wr(p[16]), .wr_data(wr_data), .stb_rd(p[10]),
        .sre_rd(p[11]), .ese_rd(p[12]), .esr_rd(p[13]), .rd_data(rd_data),
        .rd_valid(rd_valid), .spoll(p[14]), .spoll_data(spoll_data),
        .srq_o(srq_o), .srq_oe_n(srq_oe_n), .sfx_valid(p[17]),
        .sfx_char0(sfx_char0), .sfx_char1(sfx_char1),
        .sfx_hz_ohm(sfx_hz_ohm), .sfx_exp(sfx_exp), .sfx_ok(sfx_ok));
    srh_ctl_model ctl (.clk_sys(clk_sys), .srst(srst), .en(en),
        .slow(slow), .out_valid(out_valid), .out_data(out_data),
        .out_ready(out_ready), .got(got), .last(last));

    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end

    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // One-cycle strobe, taken at the second edge
    task automatic pul(int i, logic [7:0] d = 8'h00);
        @(posedge clk_sys);
        wr_data <= d;
        p[i]    <= 1'b1;
        @(posedge clk_sys);
        p[i]    <= 1'b0;
    endtask
    task automatic rd(int i, logic [7:0] e, string n);
        pul(i);
        #1;
        chk(n, e, rd_data);
        chk("rd_valid", 8'h01, {7'h00, rd_valid});
    endtask
    // Response byte held until the queue takes it
    task automatic push(logic [7:0] d);
        int k;
        @(posedge clk_sys);
        resp_valid <= 1'b1;
        resp_data  <= d;
        #1;
        for (k = 0; k < 40 && resp_ready !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        if (k == 40) begin
            error_cnt++;
            end_of_test();
        end
        @(posedge clk_sys);
        resp_valid <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        {srst, psc_clear, serial_link, query_arb} = 4'hC;
        {op_sum, qu_sum, ms_sum, resp_valid, sfx_hz_ohm, en, slow} = 7'h00;
        p = 18'h00000;
        {resp_data, wr_data, sfx_char0, sfx_char1} = 32'h00000000;
        error_cnt = 0;
        comparisons = 0;
        repeat (10) @(posedge clk_sys);
        srst      <= 1'b0;
        psc_clear <= 1'b0;
        // Power-on contents and mask write/read
        rd(13, 8'h80, "flags");
        rd(13, 8'h00, "flags");
        rd(11, 8'h00, "rmask");
        rd(12, 8'h00, "emask");
        pul(15, 8'hBD);
        pul(16, 8'hFF);
        rd(11, 8'hBD, "rmask");
        rd(12, 8'hFF, "emask");
        // Summaries, request gating and poll
        @(posedge clk_sys);
        {op_sum, qu_sum, ms_sum} <= 3'b111;
        rd(10, 8'hC9, "sbyte");
        pul(15, 8'h00);
        pul(14);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("srq_oe_n", 8'h01, {7'h00, srq_oe_n});
        pul(15, 8'h80);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("srq_oe_n", 8'h00, {7'h00, srq_oe_n});
        chk("srq_o", 8'h00, {7'h00, srq_o});
        pul(14);
        #1;
        chk("poll", 8'hC9, spoll_data);
        chk("srq_oe_n", 8'h01, {7'h00, srq_oe_n});
        @(posedge clk_sys);
        {op_sum, qu_sum, ms_sum} <= 3'b000;
        // Every event source, then masking and clearing
        for (int i = 0; i < 5; i++) begin
            pul(i);
            rd(10, 8'h20, "sbyte");
            rd(13, ev_exp[i], "flags");
        end
        pul(16, 8'hDF);
        pul(0);
        rd(10, 8'h00, "sbyte");
        pul(5);
        rd(13, 8'h00, "flags");
        rd(12, 8'hDF, "emask");
        // Unread answer then new message
        for (int i = 0; i < 3; i++) push(8'hA0 + 8'(i));
        rd(10, 8'h10, "sbyte");
        pul(7);
        rd(13, 8'h04, "flags");
        rd(10, 8'h00, "sbyte");
        @(posedge clk_sys);
        serial_link <= 1'b1;
        push(8'h5A);
        pul(7);
        pul(8);
        rd(10, 8'h10, "sbyte");
        rd(13, 8'h00, "flags");
        pul(6);
        #1;
        chk("out_valid", 8'h00, {7'h00, out_valid});
        pul(5);
        // Fill to refusal, drain with a stalling reader
        for (int i = 0; i < 16; i++) push(8'h30 + 8'(i));
        #1;
        chk("resp_ready", 8'h00, {7'h00, resp_ready});
        @(posedge clk_sys);
        {en, slow} <= 2'b11;
        for (int k = 0; k < 100 && got !== 8'h10; k++) @(posedge clk_sys);
        #1;
        chk("drained", 8'h10, got);
        chk("last", 8'h3F, last);
        rd(10, 8'h00, "sbyte");
        // Query after a text query in one message
        @(posedge clk_sys);
        {en, slow, query_arb} <= 3'b001;
        pul(9);
        pul(9);
        push(8'h55);
        pul(8);
        rd(13, 8'h04, "flags");
        rd(10, 8'h00, "sbyte");
        // Reset without zeroing keeps masks
        @(posedge clk_sys);
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        rd(11, 8'h80, "rmask");
        rd(13, 8'h80, "flags");
        // Multiplier decode table
        foreach (sfx_tab[i]) begin
            @(posedge clk_sys);
            {sfx_char0, sfx_char1} <= sfx_tab[i][31:16];
            sfx_hz_ohm <= sfx_tab[i][8];
            pul(17);
            #1;
            chk("sfx_exp", sfx_tab[i][7:0], sfx_exp);
            chk("sfx_ok", {7'h00, i != 10}, {7'h00, sfx_ok});
        end
        end_of_test();
    end
endmodule
`default_nettype wire

// [src/srh_core.sv]
// Status reporting hierarchy with output queue and suffix decoder
`timescale 1ns/1ns
`default_nettype none

module srh_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Handshakes and honest full/empty
    assign in_ready  = (count_r != (AW+1)'(DEPTH)) && !flush;
    assign out_valid = (count_r != '0);
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready && !flush;

    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys) begin
        if (srst || flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

module srh_core #(
    parameter int QUEUE_DEPTH = srh_pkg::QUEUE_DEPTH
) (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       psc_clear,
    input  wire logic       serial_link,
    input  wire logic       operation_summary,
    input  wire logic       questionable_summary,
    input  wire logic       measurement_summary,
    input  wire logic       ev_cmd_err,
    input  wire logic       ev_exe_err,
    input  wire logic       instrument_error_flag,
    input  wire logic       ev_op_done,
    input  wire logic       read_no_query,
    input  wire logic       clear_status,
    input  wire logic       instr_clear,
    input  wire logic       msg_start,
    input  wire logic       msg_end,
    input  wire logic       query_start,
    input  wire logic       query_arb,
    input  wire logic       resp_valid,
    input  wire logic [7:0] resp_data,
    output logic            resp_ready,
    output logic            out_valid,
    output logic      [7:0] out_data,
    input  wire logic       out_ready,
    input  wire logic       sre_wr,
    input  wire logic       ese_wr,
    input  wire logic [7:0] wr_data,
    input  wire logic       stb_rd,
    input  wire logic       sre_rd,
    input  wire logic       ese_rd,
    input  wire logic       esr_rd,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    input  wire logic       spoll,
    output logic      [7:0] spoll_data,
    output logic            srq_o,
    output logic            srq_oe_n,
    input  wire logic       sfx_valid,
    input  wire logic [7:0] sfx_char0,
    input  wire logic [7:0] sfx_char1,
    input  wire logic       sfx_hz_ohm,
    output logic      [7:0] sfx_exp,
    output logic            sfx_ok
);
    logic [7:0]         request_enable_mask_r;
    logic [7:0]         standard_event_mask_r;
    logic [7:0]         standard_event_flags_r;
    logic [7:0]         standard_event_flags_nxt;
    logic               rqs_r;
    logic               summary_prev_r;
    logic [7:0]         stb_base;
    logic               mss;
    logic               esb;
    logic               summary_rise;
    logic               qye_event;
    logic               queue_flush;
    logic               drop_resp;
    logic               q_in_ready;
    logic               q_in_valid;
    srh_pkg::srh_arb_t  arb_state_r;
    srh_pkg::srh_arb_t  arb_state_nxt;

    // Suffix multiplier decode, returns {ok, exponent}
    function automatic logic [8:0] sfx_decode(input logic [7:0] c0,
                                              input logic [7:0] c1,
                                              input logic       hz_ohm);
        logic [7:0] u0;
        logic [7:0] u1;
        logic [8:0] r;
        u0 = c0 & srh_pkg::CASE_MASK;
        u1 = c1 & srh_pkg::CASE_MASK;
        r  = {1'b0, 8'h00};
        if (u0 == srh_pkg::CH_M && u1 == srh_pkg::CH_A) begin
            r = {1'b1, srh_pkg::EXP_MEGA};
        end else if (u1 == srh_pkg::CH_NONE) begin
            case (u0)
                srh_pkg::CH_T: r = {1'b1, srh_pkg::EXP_TERA};
                srh_pkg::CH_G: r = {1'b1, srh_pkg::EXP_GIGA};
                srh_pkg::CH_K: r = {1'b1, srh_pkg::EXP_KILO};
                srh_pkg::CH_U: r = {1'b1, srh_pkg::EXP_MICRO};
                srh_pkg::CH_N: r = {1'b1, srh_pkg::EXP_NANO};
                srh_pkg::CH_P: r = {1'b1, srh_pkg::EXP_PICO};
                srh_pkg::CH_M: r = hz_ohm ? {1'b1, srh_pkg::EXP_MEGA}
                                          : {1'b1, srh_pkg::EXP_MILLI};
                default:       r = {1'b0, 8'h00};
            endcase
        end
        return r;
    endfunction

    // Live status byte without bit 6
    always_comb begin
        stb_base                 = 8'h00;
        stb_base[srh_pkg::SB_OPS] = operation_summary;
        stb_base[srh_pkg::SB_ESB] = esb;
        stb_base[srh_pkg::SB_MAV] = out_valid;
        stb_base[srh_pkg::SB_QES] = questionable_summary;
        stb_base[srh_pkg::SB_MEV] = measurement_summary;
    end

    // Summaries from current values
    assign esb = |(standard_event_flags_r & standard_event_mask_r);
    assign mss = |(stb_base & request_enable_mask_r);
    assign summary_rise = mss && !summary_prev_r;

    // Enable masks, kept across clears, zeroed at power-on if asked
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            if (psc_clear) begin
                request_enable_mask_r <= srh_pkg::MASK_ZERO;
                standard_event_mask_r <= srh_pkg::MASK_ZERO;
            end
        end else begin
            if (sre_wr) begin
                request_enable_mask_r <= wr_data;
            end
            if (ese_wr) begin
                standard_event_mask_r <= wr_data;
            end
        end
    end

    // Request-service bit: set on rise, cleared by poll, set wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rqs_r          <= 1'b0;
            summary_prev_r <= 1'b0;
        end else begin
            summary_prev_r <= mss;
            if (summary_rise) begin
                rqs_r <= 1'b1;
            end else if (spoll) begin
                rqs_r <= 1'b0;
            end
        end
    end

    // Open-collector request line, enable low while pulling
    assign srq_o    = 1'b0;
    assign srq_oe_n = !rqs_r;

    // Query error sources
    assign queue_flush = msg_start && out_valid && !serial_link;
    assign qye_event   = read_no_query || queue_flush
                       || (query_start && arb_state_r == srh_pkg::SRH_ARB_PEND);

    // Standard event flags, events win over read or clear
    always_comb begin
        standard_event_flags_nxt = standard_event_flags_r;
        if (esr_rd || clear_status) begin
            standard_event_flags_nxt = 8'h00;
        end
        standard_event_flags_nxt[srh_pkg::EV_CME] =
            standard_event_flags_nxt[srh_pkg::EV_CME] | ev_cmd_err;
        standard_event_flags_nxt[srh_pkg::EV_EXE] =
            standard_event_flags_nxt[srh_pkg::EV_EXE] | ev_exe_err;
        standard_event_flags_nxt[srh_pkg::EV_DDE] =
            standard_event_flags_nxt[srh_pkg::EV_DDE] | instrument_error_flag;
        standard_event_flags_nxt[srh_pkg::EV_QYE] =
            standard_event_flags_nxt[srh_pkg::EV_QYE] | qye_event;
        standard_event_flags_nxt[srh_pkg::EV_OPC] =
            standard_event_flags_nxt[srh_pkg::EV_OPC] | ev_op_done;
        standard_event_flags_nxt = standard_event_flags_nxt & srh_pkg::EV_USED;
    end

    // Event flag storage, power-on flag after reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            standard_event_flags_r <= srh_pkg::EV_RESET;
        end else begin
            standard_event_flags_r <= standard_event_flags_nxt;
        end
    end

    // Arbitrary-text query tracking within one message
    always_comb begin
        arb_state_nxt = arb_state_r;
        case (arb_state_r)
            srh_pkg::SRH_ARB_IDLE: begin
                if (query_start && query_arb && !msg_end) begin
                    arb_state_nxt = srh_pkg::SRH_ARB_PEND;
                end
            end
            srh_pkg::SRH_ARB_PEND: begin
                if (msg_end) begin
                    arb_state_nxt = srh_pkg::SRH_ARB_IDLE;
                end else if (query_start) begin
                    arb_state_nxt = srh_pkg::SRH_ARB_DROP;
                end
            end
            srh_pkg::SRH_ARB_DROP: begin
                if (msg_end) begin
                    arb_state_nxt = srh_pkg::SRH_ARB_IDLE;
                end
            end
            default: arb_state_nxt = srh_pkg::SRH_ARB_IDLE;
        endcase
    end

    // Tracker state register
    always_ff @(posedge clk_sys) begin
        if (srst || instr_clear) begin
            arb_state_r <= srh_pkg::SRH_ARB_IDLE;
        end else begin
            arb_state_r <= arb_state_nxt;
        end
    end

    // Responses of a dropped query are taken and thrown away
    assign drop_resp  = (arb_state_r == srh_pkg::SRH_ARB_DROP);
    assign q_in_valid = resp_valid && !drop_resp;
    assign resp_ready = drop_resp || q_in_ready;

    // Output queue
    srh_fifo #(
        .WIDTH (srh_pkg::QUEUE_WIDTH),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .flush     (instr_clear || queue_flush),
        .in_valid  (q_in_valid),
        .in_data   (resp_data),
        .in_ready  (q_in_ready),
        .out_valid (out_valid),
        .out_data  (out_data),
        .out_ready (out_ready)
    );

    // Register read answers, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data  <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= stb_rd || sre_rd || ese_rd || esr_rd;
            if (stb_rd) begin
                rd_data <= stb_base | {1'b0, mss, 6'b000000};
            end else if (sre_rd) begin
                rd_data <= request_enable_mask_r;
            end else if (ese_rd) begin
                rd_data <= standard_event_mask_r;
            end else if (esr_rd) begin
                rd_data <= standard_event_flags_r;
            end
        end
    end

    // Serial poll answer carries the request-service bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            spoll_data <= 8'h00;
        end else if (spoll) begin
            spoll_data <= stb_base | {1'b0, rqs_r, 6'b000000};
        end
    end

    // Suffix decode result
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sfx_exp <= 8'h00;
            sfx_ok  <= 1'b0;
        end else if (sfx_valid) begin
            {sfx_ok, sfx_exp} <= sfx_decode(sfx_char0, sfx_char1,
                                            sfx_hz_ohm);
        end
    end

    // Checks
    property p_rqs_set;
        @(posedge clk_sys) disable iff (srst)
        summary_rise |=> rqs_r;
    endproperty
    a_rqs_set: assert property (p_rqs_set)
        else $error("request-service bit not set on summary rise");

    property p_rqs_clr;
        @(posedge clk_sys) disable iff (srst)
        spoll && !summary_rise |=> !rqs_r ##1 (!rqs_r || $past(summary_rise));
    endproperty
    a_rqs_clr: assert property (p_rqs_clr)
        else $error("request-service bit survived serial poll");

    property p_srq_pin;
        @(posedge clk_sys) disable iff (srst)
        $rose(rqs_r) |-> !srq_oe_n && !srq_o;
    endproperty
    a_srq_pin: assert property (p_srq_pin)
        else $error("request line not pulled with request pending");

    property p_mav;
        @(posedge clk_sys) disable iff (srst)
        stb_rd |=> rd_data[srh_pkg::SB_MAV] == $past(out_valid)
                && rd_data[2:1] == 2'b00;
    endproperty
    a_mav: assert property (p_mav)
        else $error("status byte message bit wrong");

    property p_esr_clear;
        @(posedge clk_sys) disable iff (srst)
        esr_rd && !ev_cmd_err && !ev_exe_err && !instrument_error_flag
        && !ev_op_done && !qye_event |=> standard_event_flags_r == 8'h00;
    endproperty
    a_esr_clear: assert property (p_esr_clear)
        else $error("event flags not cleared by read");

    property p_unused_zero;
        @(posedge clk_sys) disable iff (srst)
        ##1 standard_event_flags_r[6] == 1'b0 && standard_event_flags_r[1] == 1'b0;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
        else $error("unused event flag bit set");

    property p_flush;
        @(posedge clk_sys) disable iff (srst)
        msg_start && out_valid && !serial_link |=>
            !out_valid && standard_event_flags_r[srh_pkg::EV_QYE];
    endproperty
    a_flush: assert property (p_flush)
        else $error("queue not discarded with query error");

    property p_duplex;
        @(posedge clk_sys) disable iff (srst)
        msg_start && serial_link && out_valid && !out_ready
        && !instr_clear |=> out_valid;
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("serial link lost queued response");

    property p_mask_keep;
        @(posedge clk_sys) disable iff (srst)
        (clear_status || instr_clear) && !sre_wr && !ese_wr |=>
            $stable(request_enable_mask_r) && $stable(standard_event_mask_r);
    endproperty
    a_mask_keep: assert property (p_mask_keep)
        else $error("enable mask changed by clear");

    property p_drop;
        @(posedge clk_sys) disable iff (srst)
        arb_state_r == srh_pkg::SRH_ARB_PEND && query_start && !msg_end |=>
            resp_ready && standard_event_flags_r[srh_pkg::EV_QYE];
    endproperty
    a_drop: assert property (p_drop)
        else $error("later query not suppressed");

    property p_sfx_mega;
        @(posedge clk_sys) disable iff (srst)
        sfx_valid && sfx_hz_ohm && sfx_char0 == srh_pkg::CH_M
        && sfx_char1 == srh_pkg::CH_NONE |=> sfx_ok
        && sfx_exp == srh_pkg::EXP_MEGA;
    endproperty
    a_sfx_mega: assert property (p_sfx_mega)
        else $error("mega suffix misdecoded");

    c_srq: cover property (@(posedge clk_sys) disable iff (srst)
        $rose(rqs_r) ##[1:20] spoll);
    c_full: cover property (@(posedge clk_sys) disable iff (srst)
        resp_valid && !resp_ready);
    c_flush: cover property (@(posedge clk_sys) disable iff (srst)
        queue_flush);
    c_drop: cover property (@(posedge clk_sys) disable iff (srst)
        drop_resp && resp_valid);
endmodule

`default_nettype wire

// [src/srh_pkg.sv]
// Constants and bit layout of the status reporting hierarchy
package srh_pkg;
    // Status byte bit positions
    localparam int SB_OPS = 7;
    localparam int SB_RQS = 6;
    localparam int SB_ESB = 5;
    localparam int SB_MAV = 4;
    localparam int SB_QES = 3;
    localparam int SB_MEV = 0;
    // Standard event flag bit positions
    localparam int EV_PON = 7;
    localparam int EV_CME = 5;
    localparam int EV_EXE = 4;
    localparam int EV_DDE = 3;
    localparam int EV_QYE = 2;
    localparam int EV_OPC = 0;
    localparam logic [7:0] EV_USED   = 8'hBD;
    localparam logic [7:0] EV_RESET  = 8'h80;
    localparam logic [7:0] MASK_ZERO = 8'h00;
    // Output queue shape
    localparam int QUEUE_WIDTH = 8;
    localparam int QUEUE_DEPTH = 16;
    // Suffix multiplier characters, upper case
    localparam logic [7:0] CH_T    = 8'h54;
    localparam logic [7:0] CH_G    = 8'h47;
    localparam logic [7:0] CH_M    = 8'h4D;
    localparam logic [7:0] CH_A    = 8'h41;
    localparam logic [7:0] CH_K    = 8'h4B;
    localparam logic [7:0] CH_U    = 8'h55;
    localparam logic [7:0] CH_N    = 8'h4E;
    localparam logic [7:0] CH_P    = 8'h50;
    localparam logic [7:0] CH_NONE = 8'h00;
    localparam logic [7:0] CASE_MASK = 8'hDF;
    // Decimal exponents, two's complement
    localparam logic [7:0] EXP_TERA  = 8'h0C;
    localparam logic [7:0] EXP_GIGA  = 8'h09;
    localparam logic [7:0] EXP_MEGA  = 8'h06;
    localparam logic [7:0] EXP_KILO  = 8'h03;
    localparam logic [7:0] EXP_MILLI = 8'hFD;
    localparam logic [7:0] EXP_MICRO = 8'hFA;
    localparam logic [7:0] EXP_NANO  = 8'hF7;
    localparam logic [7:0] EXP_PICO  = 8'hF4;
    // Arbitrary-text query tracking
    typedef enum logic [2:0] {
        SRH_ARB_IDLE = 3'b001,
        SRH_ARB_PEND = 3'b010,
        SRH_ARB_DROP = 3'b100
    } srh_arb_t;
endpackage
